// ==== logic/lbd_pkg.sv ====
`default_nettype none
package lbd_pkg;
   localparam int unsigned LBD_WIDTH      = 18;
   localparam int unsigned LBD_SYNC_DEPTH = 2;
   localparam logic        LBD_BIT_RESET  = 1'h0;
   // Control stages reset to their inactive level: outputs off, latch closed, edge high
   localparam logic        LBD_PIN_RESET  = 1'h1;
endpackage
`default_nettype wire

// ==== logic/lbd_bit_cell.sv ====
`timescale 1ns/10ps
`default_nettype none
module lbd_bit_cell
   import lbd_pkg::*;
(
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   input  wire logic data_in,
   input  wire logic pass_through_n_in,
   input  wire logic edge_rise_in,
   output var  logic level_out
);
   typedef struct packed {
      logic stored;
   } lbd_cell_s;

   lbd_cell_s state;
   lbd_cell_s next_state;

   always_comb begin
      next_state = state;
      if (!pass_through_n_in) begin
         next_state.stored = data_in;
      end else if (edge_rise_in) begin
         next_state.stored = data_in;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state.stored <= LBD_BIT_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign level_out = state.stored;
endmodule
`default_nettype wire

// ==== logic/lbd_bus_driver.sv ====
// Operation
// - Eighteen parallel bits, each input to its output under shared controls.
// - Output enable high puts every output in high impedance.
// - Pass-through low and enabled: outputs follow inputs, edge input ignored.
// - Pass-through high: each bit captures input on edge input rising.
// - Pass-through high, edge input steady low: hold prior output level.
// - Pass-through high, edge held high: hold, if edge rose before pass-through.
`timescale 1ns/10ps
`default_nettype none
module lbd_bus_driver
   import lbd_pkg::*;
#(
   parameter int unsigned WIDTH = LBD_WIDTH
)
(
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] data_in,
   input  wire logic             out_enable_n_in,
   input  wire logic             pass_through_n_in,
   input  wire logic             edge_in,
   output var  logic [WIDTH-1:0] bus_out,
   output var  logic [WIDTH-1:0] bus_oe_out
);
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least one");
   end

   // The pipeline below is built two stages deep and the latencies rely on it
   if (LBD_SYNC_DEPTH != 2) begin : g_bad_sync
      $error("Pin synchronisers are built two flip-flops deep");
   end

   // Pins are asynchronous, so every input passes two flip-flops first
   typedef struct packed {
      logic [WIDTH-1:0] data_m;
      logic [WIDTH-1:0] data_s;
      logic             oe_n_m;
      logic             oe_n_s;
      logic             pt_n_m;
      logic             pt_n_s;
      logic             edge_m;
      logic             edge_s;
      logic             edge_d;
   } lbd_top_s;

   lbd_top_s         state;
   lbd_top_s         next_state;
   logic             edge_rise;
   logic [WIDTH-1:0] level;

   always_comb begin
      next_state        = state;
      next_state.data_m = data_in;
      next_state.data_s = state.data_m;
      next_state.oe_n_m = out_enable_n_in;
      next_state.oe_n_s = state.oe_n_m;
      next_state.pt_n_m = pass_through_n_in;
      next_state.pt_n_s = state.pt_n_m;
      next_state.edge_m = edge_in;
      next_state.edge_s = state.edge_m;
      next_state.edge_d = state.edge_s;
   end

   // Reset high on enable and pass-through keeps outputs off until pins are seen
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state.data_m <= {WIDTH{LBD_BIT_RESET}};
         state.data_s <= {WIDTH{LBD_BIT_RESET}};
         state.oe_n_m <= LBD_PIN_RESET;
         state.oe_n_s <= LBD_PIN_RESET;
         state.pt_n_m <= LBD_PIN_RESET;
         state.pt_n_s <= LBD_PIN_RESET;
         // Edge stages reset high, so a high pin after reset gives no false rise
         state.edge_m <= LBD_PIN_RESET;
         state.edge_s <= LBD_PIN_RESET;
         state.edge_d <= LBD_PIN_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign edge_rise = state.edge_s & ~state.edge_d;

   // One decoded mode drives every cell, so follow, hold and capture never overlap
   typedef enum logic [1:0] {
      LBD_MODE_FOLLOW  = 2'h0,
      LBD_MODE_HOLD    = 2'h1,
      LBD_MODE_CAPTURE = 2'h3
   } lbd_mode_e;

   lbd_mode_e mode;
   logic      cell_pt_n;
   logic      cell_rise;

   always_comb begin
      if (!state.pt_n_s) begin
         mode = LBD_MODE_FOLLOW;
      end else if (edge_rise) begin
         mode = LBD_MODE_CAPTURE;
      end else begin
         mode = LBD_MODE_HOLD;
      end
   end

   // Raising pass-through while edge is high never makes a rise: both sync equally deep
   always_comb begin
      case (mode)
         LBD_MODE_FOLLOW: begin
            cell_pt_n = 1'h0;
            cell_rise = 1'h0;
         end
         LBD_MODE_CAPTURE: begin
            cell_pt_n = 1'h1;
            cell_rise = 1'h1;
         end
         default: begin
            cell_pt_n = 1'h1;
            cell_rise = 1'h0;
         end
      endcase
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      lbd_bit_cell u_cell (
         .clk_sys_in        (clk_sys_in),
         .rst_in            (rst_in),
         .data_in           (state.data_s[i]),
         .pass_through_n_in (cell_pt_n),
         .edge_rise_in      (cell_rise),
         .level_out         (level[i])
      );
   end

   assign bus_out = level;

   assign bus_oe_out = {WIDTH{~state.oe_n_s}};
endmodule
`default_nettype wire

// ==== verification/lbd_rx.sv ====
`timescale 1ns/10ps
`default_nettype none
module lbd_rx (
   input  wire logic [17:0] bus_in,
   input  wire logic [17:0] oe_in,
   output logic      [17:0] pin_out
);
   // No pull on the wire, so a released lane shows the inverse
   assign pin_out = ~(bus_in ^ oe_in);
endmodule
`default_nettype wire

// ==== verification/lbd_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module lbd_chk #(
   parameter int unsigned WIDTH = 18
)
(
   input wire logic             clk_sys_in,
   input wire logic             rst_in,
   input wire logic             out_enable_n_in,
   input wire logic             pass_through_n_in,
   input wire logic             edge_in,
   input wire logic [WIDTH-1:0] data_in,
   input wire logic [WIDTH-1:0] bus_out,
   input wire logic [WIDTH-1:0] bus_oe_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   oe_a: assert property (bus_oe_out == {WIDTH{!$past(out_enable_n_in, 2)}})
      else $error("oe");
   pass_a: assert property (!$past(pass_through_n_in, 3) |-> bus_out == $past(data_in, 3))
      else $error("pass");
   cap_a: assert property (pass_through_n_in[*3] ##0 $rose(edge_in)
      |-> ##3 bus_out == $past(data_in, 3)) else $error("cap");
   hold_low_a: assert property ((pass_through_n_in && !edge_in)[*6] |=> $stable(bus_out))
      else $error("hold low");
   hold_high_a: assert property ((pass_through_n_in && edge_in)[*6] |=> $stable(bus_out))
      else $error("hold high");
   change_cause_a: assert property ($changed(bus_out)
      |-> !$past(pass_through_n_in, 3) || ($past(edge_in, 3) && !$past(edge_in, 4)))
      else $error("bus changed without a cause");
endmodule
bind lbd_bus_driver lbd_chk #(.WIDTH(WIDTH)) chk (
   .clk_sys_in        (clk_sys_in),
   .rst_in            (rst_in),
   .out_enable_n_in   (out_enable_n_in),
   .pass_through_n_in (pass_through_n_in),
   .edge_in           (edge_in),
   .data_in           (data_in),
   .bus_out           (bus_out),
   .bus_oe_out        (bus_oe_out)
);
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk_sys_in        = 1'h0;
   logic        rst_in            = 1'h1;
   logic        out_enable_n_in   = 1'h1;
   logic        pass_through_n_in = 1'h1;
   logic        edge_in           = 1'h0;
   logic [17:0] data_in           = 18'h0;
   logic [17:0] bus_out;
   logic [17:0] bus_oe_out;
   logic [17:0] pin;
   int          err_count         = 0;
   int          num_checks        = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   lbd_bus_driver dut (
      .clk_sys_in        (clk_sys_in),
      .rst_in            (rst_in),
      .data_in           (data_in),
      .out_enable_n_in   (out_enable_n_in),
      .pass_through_n_in (pass_through_n_in),
      .edge_in           (edge_in),
      .bus_out           (bus_out),
      .bus_oe_out        (bus_oe_out)
   );
   lbd_rx rx (
      .bus_in  (bus_out),
      .oe_in   (bus_oe_out),
      .pin_out (pin)
   );
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #5;
   endtask
   task automatic chk(input string s, input logic [17:0] e, input logic [17:0] v);
      num_checks++;
      if (v !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", s, e, v);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Follow with edge held high, then close the latch while edge is already high
   task automatic t_pass;
      out_enable_n_in   = 1'h0;
      pass_through_n_in = 1'h0;
      data_in           = 18'h2a5c3;
      cyc(4);
      chk("pin", 18'h2a5c3, pin);
      chk("oe", 18'h3ffff, bus_oe_out);
      edge_in = 1'h1;
      cyc(3);
      data_in = 18'h0c3a5;
      cyc(4);
      chk("pin", 18'h0c3a5, pin);
      pass_through_n_in = 1'h1;
      cyc(2);
      data_in = 18'h3f00f;
      cyc(6);
      chk("pin", 18'h0c3a5, pin);
      out_enable_n_in = 1'h1;
      edge_in         = 1'h0;
      cyc(3);
      chk("oe", 18'h0, bus_oe_out);
      chk("bus", 18'h0c3a5, bus_out);
   endtask
   // Capture with outputs off, hold under high and low edge, capture again enabled
   task automatic t_cap;
      data_in = 18'h15a3c;
      cyc(3);
      edge_in = 1'h1;
      cyc(3);
      data_in = 18'h3ffff;
      cyc(6);
      out_enable_n_in = 1'h0;
      cyc(3);
      chk("cap", 18'h15a3c, pin);
      edge_in = 1'h0;
      cyc(8);
      chk("hold", 18'h15a3c, pin);
      edge_in = 1'h1;
      cyc(4);
      chk("cap", 18'h3ffff, pin);
   endtask
   // Reset in mid-run clears storage and turns the outputs off
   task automatic t_reset;
      rst_in          = 1'h1;
      edge_in         = 1'h0;
      out_enable_n_in = 1'h1;
      #1;
      chk("rst bus", 18'h0, bus_out);
      chk("rst oe", 18'h0, bus_oe_out);
      cyc(3);
      rst_in = 1'h0;
      cyc(2);
      chk("rel oe", 18'h0, bus_oe_out);
      out_enable_n_in = 1'h0;
      cyc(3);
      chk("rel pin", 18'h0, pin);
   endtask
   initial begin
      cyc(6);
      chk("rst bus", 18'h0, bus_out);
      chk("rst oe", 18'h0, bus_oe_out);
      rst_in = 1'h0;
      cyc(2);
      t_pass;
      t_cap;
      t_reset;
      stop_test;
   end
endmodule
`default_nettype wire
